// ---- design/mxe_instr_exec.sv ----
`timescale 1ns/10ps
`include "mxe_map.svh"

module mxe_instr_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issueValid,
  output logic issueReady,
  input wire mxe_pkg::mxe_instr_t instr,
  input wire logic [7:0] curPage,
  input wire mxe_pkg::mxe_core_wr_t coreWr,
  output logic progRd,
  output logic [15:0] progAddr,
  input wire logic [15:0] progData,
  output logic [7:0] acc,
  output logic zFlag,
  output logic [7:0] tblPtrLow,
  output logic [7:0] tblPtrHigh,
  output logic [7:0] tblHigh,
  input wire logic [7:0] memRdAddr,
  output logic [7:0] memRdData,
  output logic done,
  output logic skipTaken,
  output logic dummyCycle
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic isSkipOp(input mxe_pkg::mxe_op_t op);
    isSkipOp = (op == mxe_pkg::OP_SKIP_IF_ZERO) || (op == mxe_pkg::OP_COPY_AND_SKIP_ZERO)
      || (op == mxe_pkg::OP_SKIP_IF_BIT_ZERO);
  endfunction

  function automatic logic isTableOp(input mxe_pkg::mxe_op_t op);
    isTableOp = (op == mxe_pkg::OP_TABLE_READ_CURRENT_PAGE)
      || (op == mxe_pkg::OP_TABLE_READ_LAST_PAGE)
      || (op == mxe_pkg::OP_INCR_TABLE_READ)
      || (op == mxe_pkg::OP_INCR_TABLE_READ_LAST_PAGE);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] dataMem [0:`MXE_MEM_WORDS-1];
  mxe_pkg::mxe_state_t state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic zFlag_r, zFlag_nxt;
  logic [7:0] ptrLow_r, ptrLow_nxt;
  logic [7:0] ptrHigh_r, ptrHigh_nxt;
  logic [7:0] tblHigh_r, tblHigh_nxt;
  logic [7:0] pendAddr_r, pendAddr_nxt;
  logic progRd_r, progRd_nxt;
  logic [15:0] progAddr_r, progAddr_nxt;
  logic [7:0] memRdData_r, memRdData_nxt;
  logic done_r, done_nxt;
  logic skip_r, skip_nxt;
  logic memWe;
  logic [7:0] memWa;
  logic [7:0] memWd;
  logic accept;
  logic skipCond;
  logic [7:0] opnd;
  logic [7:0] xorVal;
  logic [7:0] ptrInc;

  assign issueReady = (state_r == mxe_pkg::ST_IDLE);
  assign accept = issueValid && issueReady;
  assign opnd = dataMem[instr.addr];
  assign xorVal = acc_r ^ opnd;
  assign ptrInc = ptrLow_r + `MXE_PTR_STEP;

  always_comb begin
    case (instr.op)
      mxe_pkg::OP_SKIP_IF_ZERO: skipCond = (opnd == 8'h00);
      mxe_pkg::OP_COPY_AND_SKIP_ZERO: skipCond = (opnd == 8'h00);
      mxe_pkg::OP_SKIP_IF_BIT_ZERO: skipCond = !opnd[instr.bitSel];
      default: skipCond = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    zFlag_nxt = zFlag_r;
    ptrLow_nxt = ptrLow_r;
    ptrHigh_nxt = ptrHigh_r;
    tblHigh_nxt = tblHigh_r;
    pendAddr_nxt = pendAddr_r;
    progRd_nxt = 1'b0;
    progAddr_nxt = progAddr_r;
    done_nxt = 1'b0;
    skip_nxt = 1'b0;
    memWe = 1'b0;
    memWa = instr.addr;
    memWd = 8'h00;
    memRdData_nxt = dataMem[memRdAddr];
    case (state_r)
      mxe_pkg::ST_IDLE: begin
        if (accept) begin
          done_nxt = !isTableOp(instr.op);
          pendAddr_nxt = instr.addr;
          case (instr.op)
            mxe_pkg::OP_NIBBLE_SWAP_TO_ACC: begin
              acc_nxt = {opnd[3:0], opnd[7:4]};
            end
            mxe_pkg::OP_COPY_AND_SKIP_ZERO: begin
              acc_nxt = opnd;
            end
            mxe_pkg::OP_TABLE_READ_CURRENT_PAGE: begin
              progRd_nxt = 1'b1;
              progAddr_nxt = {curPage, ptrLow_r};
            end
            mxe_pkg::OP_TABLE_READ_LAST_PAGE: begin
              progRd_nxt = 1'b1;
              progAddr_nxt = {`MXE_LAST_PAGE, ptrLow_r};
            end
            mxe_pkg::OP_INCR_TABLE_READ: begin
              ptrLow_nxt = ptrInc;
              progRd_nxt = 1'b1;
              progAddr_nxt = {ptrHigh_r, ptrInc};
            end
            mxe_pkg::OP_INCR_TABLE_READ_LAST_PAGE: begin
              ptrLow_nxt = ptrInc;
              progRd_nxt = 1'b1;
              progAddr_nxt = {`MXE_LAST_PAGE, ptrInc};
            end
            mxe_pkg::OP_XOR_TO_ACC: begin
              acc_nxt = xorVal;
              zFlag_nxt = (xorVal == 8'h00);
            end
            mxe_pkg::OP_XOR_TO_MEMORY: begin
              memWe = 1'b1;
              memWd = xorVal;
              zFlag_nxt = (xorVal == 8'h00);
            end
            default: begin
            end
          endcase
          if (isTableOp(instr.op)) begin
            state_nxt = mxe_pkg::ST_FETCH;
          end else if (isSkipOp(instr.op) && skipCond) begin
            skip_nxt = 1'b1;
            state_nxt = mxe_pkg::ST_DUMMY;
          end else begin
            state_nxt = mxe_pkg::ST_IDLE;
          end
        end else begin
          // Core side loads only while no instruction is issued
          if (coreWr.memWe) begin
            memWe = 1'b1;
            memWa = coreWr.addr;
            memWd = coreWr.data;
          end
          if (coreWr.accWe) begin
            acc_nxt = coreWr.data;
          end
          if (coreWr.ptrLowWe) begin
            ptrLow_nxt = coreWr.data;
          end
          if (coreWr.ptrHighWe) begin
            ptrHigh_nxt = coreWr.data;
          end
        end
      end
      mxe_pkg::ST_FETCH: begin
        // Program word is sampled in the same cycle as the read strobe
        memWe = 1'b1;
        memWa = pendAddr_r;
        memWd = progData[7:0];
        tblHigh_nxt = progData[15:8];
        done_nxt = 1'b1;
        state_nxt = mxe_pkg::ST_IDLE;
      end
      mxe_pkg::ST_DUMMY: begin
        state_nxt = mxe_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = mxe_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= mxe_pkg::ST_IDLE;
      acc_r <= `MXE_ACC_RST;
      zFlag_r <= `MXE_ZF_RST;
      ptrLow_r <= `MXE_PTR_RST;
      ptrHigh_r <= `MXE_PTR_RST;
      tblHigh_r <= `MXE_TABLE_READ_HIGH_BYTE_RST;
      pendAddr_r <= 8'h00;
      progRd_r <= 1'b0;
      progAddr_r <= `MXE_ADDR_RST;
      memRdData_r <= 8'h00;
      done_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      zFlag_r <= zFlag_nxt;
      ptrLow_r <= ptrLow_nxt;
      ptrHigh_r <= ptrHigh_nxt;
      tblHigh_r <= tblHigh_nxt;
      pendAddr_r <= pendAddr_nxt;
      progRd_r <= progRd_nxt;
      progAddr_r <= progAddr_nxt;
      memRdData_r <= memRdData_nxt;
      done_r <= done_nxt;
      skip_r <= skip_nxt;
    end
  end

  // Memory carries no reset; contents are undefined until loaded
  always_ff @(posedge clk) begin
    if (memWe) begin
      dataMem[memWa] <= memWd;
    end
  end

  assign acc = acc_r;
  assign zFlag = zFlag_r;
  assign tblPtrLow = ptrLow_r;
  assign tblPtrHigh = ptrHigh_r;
  assign tblHigh = tblHigh_r;
  assign progRd = progRd_r;
  assign progAddr = progAddr_r;
  assign memRdData = memRdData_r;
  assign done = done_r;
  assign skipTaken = skip_r;
  assign dummyCycle = (state_r == mxe_pkg::ST_DUMMY);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_dummy;
    (skipTaken && dummyCycle && !issueReady) ##1 (issueReady && !dummyCycle);
  endsequence

  sequence s_fetch_done;
    ##1 (done && tblHigh == $past(progData[15:8]));
  endsequence

  property p_swap;
    accept && instr.op == mxe_pkg::OP_NIBBLE_SWAP_TO_ACC |=>
      acc == {$past(opnd[3:0]), $past(opnd[7:4])} && $stable(zFlag) && done;
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap result wrong");

  property p_skip_zero;
    accept && instr.op == mxe_pkg::OP_SKIP_IF_ZERO |=>
      skipTaken == ($past(opnd) == 8'h00) && $stable(zFlag) && $stable(acc);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("byte skip wrong");

  property p_skip_dummy;
    accept && isSkipOp(instr.op) && skipCond |-> ##1 s_dummy;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip lacks dummy");

  property p_copy_skip;
    accept && instr.op == mxe_pkg::OP_COPY_AND_SKIP_ZERO |=>
      acc == $past(opnd) && skipTaken == (acc == 8'h00) && $stable(zFlag);
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy skip wrong");

  property p_bit_skip;
    accept && instr.op == mxe_pkg::OP_SKIP_IF_BIT_ZERO |=>
      skipTaken == !$past(opnd[instr.bitSel]) && $stable(zFlag);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  property p_tab_cur;
    accept && instr.op == mxe_pkg::OP_TABLE_READ_CURRENT_PAGE |=>
      (progRd && progAddr == {$past(curPage), $past(ptrLow_r)}) ##0 s_fetch_done;
  endproperty
  a_tab_cur: assert property (p_tab_cur) else $error("current page read wrong");

  property p_tab_last;
    accept && instr.op == mxe_pkg::OP_TABLE_READ_LAST_PAGE |=>
      (progRd && progAddr == {`MXE_LAST_PAGE, $past(ptrLow_r)}) ##0 s_fetch_done;
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page read wrong");

  property p_tab_inc;
    accept && instr.op == mxe_pkg::OP_INCR_TABLE_READ |=>
      (tblPtrLow == 8'($past(ptrLow_r) + 8'h01) && progAddr == {tblPtrHigh, tblPtrLow})
      ##0 s_fetch_done;
  endproperty
  a_tab_inc: assert property (p_tab_inc) else $error("incrementing read wrong");

  property p_tab_inc_last;
    accept && instr.op == mxe_pkg::OP_INCR_TABLE_READ_LAST_PAGE |=>
      (tblPtrLow == 8'($past(ptrLow_r) + 8'h01) && progAddr == {`MXE_LAST_PAGE, tblPtrLow})
      ##0 s_fetch_done;
  endproperty
  a_tab_inc_last: assert property (p_tab_inc_last) else $error("inc last read wrong");

  property p_xor_acc;
    accept && instr.op == mxe_pkg::OP_XOR_TO_ACC |=>
      acc == $past(xorVal) && zFlag == (acc == 8'h00);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

  property p_xor_mem;
    accept && instr.op == mxe_pkg::OP_XOR_TO_MEMORY |->
      memWe && memWa == instr.addr && memWd == xorVal
      ##1 (zFlag == ($past(xorVal) == 8'h00) && $stable(acc));
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_no_skip;
    accept && isSkipOp(instr.op) && !skipCond |=> !skipTaken && issueReady && done;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("failed skip stalled");

endmodule

// ---- design/mxe_map.svh ----
// Notes on behaviour
// - Swap-to-accumulator puts operand high nibble low, low nibble high; no flags.
// - Byte skip-if-zero skips next instruction when operand is zero; no flags.
// - A taken skip adds one dummy instruction cycle; two cycles in total.
// - Copy-and-skip loads operand into accumulator, skips when it is zero.
// - Bit skip-if-zero skips next instruction when the selected bit is zero.
// - Current-page table read: low byte to memory, high byte to table-high.
// - Last-page table read uses the last page with the pointer low byte.
// - Incrementing table read bumps pointer low, then reads at both pointer bytes.
// - Incrementing last-page read bumps pointer low, then reads the last page.
// - XOR to accumulator stores accumulator XOR operand; only zero flag changes.
// - XOR to memory stores accumulator XOR operand in memory; only zero flag.
`ifndef MXE_MAP_SVH
`define MXE_MAP_SVH

// ----------------------------------------
// Constants
// ----------------------------------------
`define MXE_LAST_PAGE 8'hFF
`define MXE_ACC_RST 8'h00
`define MXE_PTR_RST 8'h00
`define MXE_TABLE_READ_HIGH_BYTE_RST 8'h00
`define MXE_ZF_RST 1'b0
`define MXE_ADDR_RST 16'h0000
`define MXE_PTR_STEP 8'h01
`define MXE_MEM_WORDS 256

`endif

// ---- design/mxe_pkg.sv ----
package mxe_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_NIBBLE_SWAP_TO_ACC = 4'h1,
    OP_SKIP_IF_ZERO = 4'h2,
    OP_COPY_AND_SKIP_ZERO = 4'h3,
    OP_SKIP_IF_BIT_ZERO = 4'h4,
    OP_TABLE_READ_CURRENT_PAGE = 4'h5,
    OP_TABLE_READ_LAST_PAGE = 4'h6,
    OP_INCR_TABLE_READ = 4'h7,
    OP_INCR_TABLE_READ_LAST_PAGE = 4'h8,
    OP_XOR_TO_ACC = 4'h9,
    OP_XOR_TO_MEMORY = 4'hA
  } mxe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_DUMMY = 2'b10
  } mxe_state_t;

  typedef struct packed {
    mxe_op_t op;
    logic [7:0] addr;
    logic [2:0] bitSel;
  } mxe_instr_t;

  typedef struct packed {
    logic memWe;
    logic accWe;
    logic ptrLowWe;
    logic ptrHighWe;
    logic [7:0] addr;
    logic [7:0] data;
  } mxe_core_wr_t;

endpackage

// ---- tb/mxe_instr_exec_tb_top.sv ----
`timescale 1ns/10ps
`include "mxe_map.svh"

module mxe_instr_exec_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic issueValid = 1'b0;
  logic issueReady;
  mxe_pkg::mxe_instr_t instr = '0;
  logic [7:0] curPage = 8'h00;
  mxe_pkg::mxe_core_wr_t coreWr = '0;
  logic progRd;
  logic [15:0] progAddr;
  logic [15:0] progData = 16'h0000;
  logic [7:0] acc;
  logic zFlag;
  logic [7:0] tblPtrLow;
  logic [7:0] tblPtrHigh;
  logic [7:0] tblHigh;
  logic [7:0] memRdAddr = 8'h00;
  logic [7:0] memRdData;
  logic done;
  logic skipTaken;
  logic dummyCycle;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  mxe_instr_exec uut (.clk(clk), .resetn(resetn), .issueValid(issueValid),
    .issueReady(issueReady), .instr(instr), .curPage(curPage), .coreWr(coreWr),
    .progRd(progRd), .progAddr(progAddr), .progData(progData), .acc(acc), .zFlag(zFlag),
    .tblPtrLow(tblPtrLow), .tblPtrHigh(tblPtrHigh), .tblHigh(tblHigh),
    .memRdAddr(memRdAddr), .memRdData(memRdData), .done(done), .skipTaken(skipTaken),
    .dummyCycle(dummyCycle));

  always #10 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Core load port: we = {memWe, accWe, ptrLowWe, ptrHighWe}
  task automatic core(input logic [3:0] we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    coreWr <= {we, a, d};
    @(posedge clk);
    coreWr <= '0;
  endtask

  task automatic readm(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    memRdAddr <= a;
    @(posedge clk);
    #1;
    v = memRdData;
  endtask

  // Offer one instruction; returns just after the edge that raises done
  task automatic exec(input mxe_pkg::mxe_op_t op, input logic [7:0] a, input logic [2:0] b,
    input logic [15:0] w, input logic [15:0] expAddr);
    logic isTbl;
    isTbl = op inside {mxe_pkg::OP_TABLE_READ_CURRENT_PAGE, mxe_pkg::OP_TABLE_READ_LAST_PAGE,
      mxe_pkg::OP_INCR_TABLE_READ, mxe_pkg::OP_INCR_TABLE_READ_LAST_PAGE};
    @(posedge clk);
    issueValid <= 1'b1;
    instr <= {op, a, b};
    // Stale program word is inverted so an early sample cannot pass by luck
    progData <= ~progData;
    @(posedge clk);
    issueValid <= 1'b0;
    progData <= w;
    if (isTbl) begin
      #1;
      chk(progRd, 16'h0001, "read strobe");
      chk(progAddr, expAddr, "program address");
      @(posedge clk);
    end
    #1;
    chk(done, 16'h0001, "done");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_xor();
    logic [7:0] v;
    core(4'h4, 8'h00, 8'h3C);
    core(4'h8, 8'h51, 8'h0F);
    core(4'h8, 8'h50, 8'h3C);
    // Flag set first, so a missing update on the memory form shows up
    exec(mxe_pkg::OP_XOR_TO_ACC, 8'h50, 3'h0, 16'h0000, 16'h0000);
    chk(acc, 16'h0000, "first xor to acc result");
    chk(zFlag, 16'h0001, "zero flag after first xor to acc");
    core(4'h4, 8'h00, 8'h3C);
    exec(mxe_pkg::OP_XOR_TO_MEMORY, 8'h51, 3'h0, 16'h0000, 16'h0000);
    chk(zFlag, 16'h0000, "zero flag after xor to memory");
    chk(acc, 16'h003C, "acc kept by xor to memory");
    readm(8'h51, v);
    chk(v, 16'h0033, "xor to memory result");
    exec(mxe_pkg::OP_XOR_TO_ACC, 8'h50, 3'h0, 16'h0000, 16'h0000);
    chk(acc, 16'h0000, "xor to acc result");
    chk(zFlag, 16'h0001, "zero flag after xor to acc");
    $display("xor test finished");
  endtask

  task automatic t_swap();
    logic [7:0] v;
    core(4'h8, 8'h10, 8'hA5);
    exec(mxe_pkg::OP_NIBBLE_SWAP_TO_ACC, 8'h10, 3'h0, 16'h0000, 16'h0000);
    chk(acc, 16'h005A, "swapped acc");
    chk(zFlag, 16'h0001, "flag kept by swap");
    readm(8'h10, v);
    chk(v, 16'h00A5, "operand kept by swap");
    $display("swap test finished");
  endtask

  // One skip-type op; checks the taken or failed timing
  task automatic skip_one(input mxe_pkg::mxe_op_t op, input logic [7:0] a,
    input logic [2:0] b, input logic exp);
    exec(op, a, b, 16'h0000, 16'h0000);
    chk(skipTaken, {15'h0, exp}, "skip decision");
    chk(dummyCycle, {15'h0, exp}, "dummy cycle");
    chk(issueReady, {15'h0, ~exp}, "ready in second cycle");
    chk(zFlag, 16'h0001, "flag kept by skip");
    @(posedge clk);
    #1;
    chk(issueReady, 16'h0001, "ready after skip");
    chk(dummyCycle, 16'h0000, "single dummy cycle");
  endtask

  task automatic t_skip();
    core(4'h8, 8'h20, 8'h00);
    core(4'h8, 8'h21, 8'h01);
    skip_one(mxe_pkg::OP_SKIP_IF_ZERO, 8'h20, 3'h0, 1'b1);
    skip_one(mxe_pkg::OP_SKIP_IF_ZERO, 8'h21, 3'h0, 1'b0);
    chk(acc, 16'h005A, "acc kept by byte skip");
    core(4'h8, 8'h22, 8'h80);
    skip_one(mxe_pkg::OP_COPY_AND_SKIP_ZERO, 8'h22, 3'h0, 1'b0);
    chk(acc, 16'h0080, "copy to acc");
    skip_one(mxe_pkg::OP_COPY_AND_SKIP_ZERO, 8'h20, 3'h0, 1'b1);
    chk(acc, 16'h0000, "copy zero to acc");
    core(4'h8, 8'h30, 8'hF7);
    for (int i = 0; i < 8; i++) begin
      skip_one(mxe_pkg::OP_SKIP_IF_BIT_ZERO, 8'h30, i[2:0], i == 3);
    end
    chk(acc, 16'h0000, "acc kept by bit skip");
    $display("skip test finished");
  endtask

  task automatic t_table();
    mxe_pkg::mxe_op_t ops[4];
    logic [15:0] adr[4];
    logic [7:0] ptr[4];
    logic [7:0] v;
    ops = '{mxe_pkg::OP_TABLE_READ_CURRENT_PAGE, mxe_pkg::OP_TABLE_READ_LAST_PAGE,
      mxe_pkg::OP_INCR_TABLE_READ, mxe_pkg::OP_INCR_TABLE_READ_LAST_PAGE};
    // Last op wraps the low pointer from FF to 00
    adr = '{16'h34FE, {`MXE_LAST_PAGE, 8'hFE}, 16'h12FF, {`MXE_LAST_PAGE, 8'h00}};
    ptr = '{8'hFE, 8'hFE, 8'hFF, 8'h00};
    @(posedge clk);
    curPage <= 8'h34;
    core(4'h2, 8'h00, 8'hFE);
    core(4'h1, 8'h00, 8'h12);
    for (int i = 0; i < 4; i++) begin
      exec(ops[i], 8'h40 + i[7:0], 3'h0, {8'hC0 + i[7:0], 8'h17 + i[7:0]}, adr[i]);
      chk(tblHigh, {8'h00, 8'hC0 + i[7:0]}, "table high byte");
      chk(tblPtrLow, {8'h00, ptr[i]}, "pointer low");
      chk(tblPtrHigh, 16'h0012, "pointer high kept");
      chk(zFlag, 16'h0001, "flag kept by table read");
      readm(8'h40 + i[7:0], v);
      chk(v, {8'h00, 8'h17 + i[7:0]}, "table low byte");
    end
    $display("table test finished");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("BAD at %0t: run did not finish in time", $time);
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(acc, {8'h00, `MXE_ACC_RST}, "acc after reset");
    chk(issueReady, 16'h0001, "ready after reset");
    chk(done, 16'h0000, "done after reset");
    t_xor();
    t_swap();
    t_skip();
    t_table();
    close_out();
  end
endmodule
